// [design/result_buffer.sv]
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module result_buffer
    import tape_label_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    input wire result_t i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output result_t o_out_data,
    input wire logic i_out_ready
);
    typedef struct packed {
        result_t [1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t s_reg;
    buf_state_t s_next;
    logic push;
    logic pop;

    assign o_in_ready = (s_reg.count != 2'h2);
    assign o_out_valid = (s_reg.count != 2'h0);
    assign o_out_data = s_reg.mem[s_reg.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr_ptr] = i_in_data;
            s_next.wr_ptr = ~s_reg.wr_ptr;
        end
        if (pop) begin
            s_next.rd_ptr = ~s_reg.rd_ptr;
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 2'h1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : result_buffer

// [design/tape_label_map.svh]
// constants for the tape label position interpreter
// Behaviour
// - coarse tape: numeric set C labels step by 4, one per 40 mm
// - fine tape: numeric set C labels step by 3, one per 30 mm
// - grid select input chooses the grid; low means 40 mm, the default
// - set B control labels are kept apart from numeric position labels
// - tape switch happens at the same point in both travel directions
// - at the switch middle with a new tape label seen, move to that tape
// - no new tape at the switch middle: hold old tape for half a label
// - past the output stop label middle no position is output
// - after a switch the new tape value is taken relative to the centre
// - marker labels are decoded and handed to the host
// - a marker is a letter then two decimal digits, three characters
// - markers are read from the set B slot like control labels
// - one result per scan, one scan every millisecond
`ifndef TAPE_LABEL_MAP_SVH
`define TAPE_LABEL_MAP_SVH

`define CLK_PERIOD_NS 5
`define SCAN_PERIOD_NS 1000000
`define SCAN_PERIOD_CYC ((`SCAN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COARSE_STEP 4
`define FINE_STEP 3
`define COARSE_GRID_MM 40
`define FINE_GRID_MM 30
`define MM_PER_COUNT 10
`define MIN_JUMP_MM 1000
`define MIN_JUMP_COUNTS (`MIN_JUMP_MM / `MM_PER_COUNT)
`define MARKER_LEN 2'h3
// label contents of the two control labels; plain defaults
`define SWITCH_CODE 24'h4D5653
`define STOP_CODE 24'h4D5630
`define CHAR_UP_A 8'h41
`define CHAR_UP_Z 8'h5A
`define CHAR_LO_A 8'h61
`define CHAR_LO_Z 8'h7A
`define CHAR_0 8'h30
`define CHAR_9 8'h39

`endif

// [design/tape_label_pkg.sv]
// types shared by the tape label position interpreter
package tape_label_pkg;

    typedef enum logic [2:0] {
        ST_TRACK = 3'b001,
        ST_HOLD = 3'b010,
        ST_STOP = 3'b100
    } mode_t;

    // one decoded scan: set B slot (control or marker) and set C slot (position)
    typedef struct packed {
        logic ctrl_ok;
        logic [1:0] ctrl_len;
        logic [23:0] ctrl_chars;
        logic signed [15:0] ctrl_off;
        logic pos_ok;
        logic [23:0] pos_val;
        logic signed [15:0] pos_off;
    } scan_t;

    typedef struct packed {
        logic pos_valid;
        logic signed [31:0] position;
        logic mark_valid;
        logic [23:0] mark_chars;
    } result_t;

endpackage : tape_label_pkg

// [design/tape_label_position_interpreter.sv]
// label interpreter: position, tape switch, output stop and markers
`timescale 1ns/1ps
`include "tape_label_map.svh"
module tape_label_position_interpreter
    import tape_label_pkg::*;
#(
    parameter int SCAN_CYC = `SCAN_PERIOD_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_GRID_FINE,
    input wire logic I_SCAN_VALID,
    input wire scan_t I_SCAN,
    output logic O_SCAN_READY,
    output logic O_RES_VALID,
    output result_t O_RES,
    input wire logic I_RES_READY
);
    typedef struct packed {
        mode_t mode;
        logic ref_ok;
        logic [23:0] tape_ref;
        logic pos_ok;
        logic signed [31:0] cur_pos;
        logic signed [31:0] sw_mid;
        logic ctrl_seen;
        logic ctrl_side;
        logic [17:0] tick_cnt;
        logic mark_pend;
        logic [23:0] mark_chars;
        logic res_pend;
        result_t res;
    } core_state_t;

    core_state_t s_reg;
    core_state_t s_next;
    logic buf_ready;
    logic fire;
    logic tick;
    logic pos_in;
    logic near;
    logic is_sw;
    logic is_stop;
    logic side;
    logic crossed;
    logic in_half;
    logic signed [24:0] diff;
    logic signed [31:0] new_pos;
    logic signed [31:0] hold_pos;
    logic signed [15:0] half_mm;

    function automatic logic is_letter(input logic [7:0] c);
        return (c >= `CHAR_UP_A && c <= `CHAR_UP_Z) || (c >= `CHAR_LO_A && c <= `CHAR_LO_Z);
    endfunction : is_letter

    function automatic logic is_digit(input logic [7:0] c);
        return c >= `CHAR_0 && c <= `CHAR_9;
    endfunction : is_digit

    function automatic logic is_marker(input logic [1:0] len, input logic [23:0] ch);
        return len == `MARKER_LEN && is_letter(ch[23:16]) && is_digit(ch[15:8])
            && is_digit(ch[7:0]);
    endfunction : is_marker

    function automatic logic on_grid(input logic [23:0] v, input logic fine);
        if (fine) begin
            return (v % 24'(`FINE_STEP)) == 24'h000000;
        end
        return (v % 24'(`COARSE_STEP)) == 24'h000000;
    endfunction : on_grid

    function automatic logic signed [31:0] to_pos(input logic [23:0] v,
                                                  input logic signed [15:0] off);
        logic signed [31:0] base;
        base = 32'($signed({8'h00, v}) * 32'sd10);
        return base - 32'(off);
    endfunction : to_pos

    assign O_SCAN_READY = !s_reg.res_pend;
    assign fire = I_SCAN_VALID && O_SCAN_READY;
    assign tick = (s_reg.tick_cnt == 18'(SCAN_CYC - 1));
    assign pos_in = I_SCAN.pos_ok && on_grid(I_SCAN.pos_val, I_GRID_FINE);
    assign diff = $signed({1'b0, I_SCAN.pos_val}) - $signed({1'b0, s_reg.tape_ref});
    assign near = s_reg.ref_ok && diff < 25'sd100 && diff > -25'sd100;
    // set B slot only; numeric labels never enter here
    assign is_sw = I_SCAN.ctrl_ok && I_SCAN.ctrl_len == `MARKER_LEN
        && I_SCAN.ctrl_chars == `SWITCH_CODE;
    assign is_stop = I_SCAN.ctrl_ok && I_SCAN.ctrl_len == `MARKER_LEN
        && I_SCAN.ctrl_chars == `STOP_CODE;
    assign side = I_SCAN.ctrl_off > 16'sh0000;
    // middle reached from either side counts the same
    assign crossed = (s_reg.ctrl_seen && side != s_reg.ctrl_side)
        || I_SCAN.ctrl_off == 16'sh0000;
    assign new_pos = to_pos(I_SCAN.pos_val, I_SCAN.pos_off);
    assign hold_pos = s_reg.sw_mid - 32'(I_SCAN.ctrl_off);
    assign half_mm = I_GRID_FINE ? 16'sh000F : 16'sh0014;
    assign in_half = I_SCAN.ctrl_off <= half_mm && I_SCAN.ctrl_off >= -half_mm;

    always_comb begin
        s_next = s_reg;
        s_next.tick_cnt = tick ? 18'h00000 : s_reg.tick_cnt + 18'h00001;
        if (s_reg.res_pend && buf_ready) begin
            s_next.res_pend = 1'b0;
        end
        if (fire) begin
            s_next.ctrl_seen = I_SCAN.ctrl_ok && (is_sw || is_stop);
            s_next.ctrl_side = side;
            if (I_SCAN.ctrl_ok && is_marker(I_SCAN.ctrl_len, I_SCAN.ctrl_chars)
                && !is_sw && !is_stop) begin
                s_next.mark_pend = 1'b1;
                s_next.mark_chars = I_SCAN.ctrl_chars;
            end
            case (s_reg.mode)
                ST_TRACK: begin
                    if (is_sw && crossed) begin
                        if (pos_in && !near) begin
                            s_next.tape_ref = I_SCAN.pos_val;
                            s_next.cur_pos = new_pos;
                            s_next.pos_ok = 1'b1;
                        end else begin
                            // keep the old tape running from the switch middle, not a stale value
                            s_next.mode = ST_HOLD;
                            s_next.sw_mid = s_reg.ctrl_seen ? s_reg.sw_mid : s_reg.cur_pos;
                            s_next.cur_pos = s_reg.ctrl_seen ? hold_pos : s_reg.cur_pos;
                            s_next.pos_ok = s_reg.pos_ok && in_half;
                        end
                    end else if (is_stop && crossed) begin
                        s_next.mode = ST_STOP;
                        s_next.pos_ok = 1'b0;
                    end else begin
                        if (is_sw) begin
                            s_next.sw_mid = s_reg.cur_pos + 32'(I_SCAN.ctrl_off);
                        end
                        if (pos_in && (!s_reg.ref_ok || near)) begin
                            s_next.ref_ok = 1'b1;
                            s_next.tape_ref = I_SCAN.pos_val;
                            s_next.cur_pos = new_pos;
                            s_next.pos_ok = 1'b1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (pos_in && !near) begin
                        s_next.mode = ST_TRACK;
                        s_next.tape_ref = I_SCAN.pos_val;
                        s_next.cur_pos = new_pos;
                        s_next.pos_ok = 1'b1;
                    end else if ((pos_in && near) || (is_sw && crossed)) begin
                        s_next.mode = ST_TRACK;
                        s_next.cur_pos = pos_in ? new_pos : s_reg.cur_pos;
                        s_next.pos_ok = 1'b1;
                    end else if (is_sw && in_half) begin
                        s_next.cur_pos = hold_pos;
                        s_next.pos_ok = 1'b1;
                    end else begin
                        s_next.pos_ok = 1'b0;
                    end
                end
                ST_STOP: begin
                    s_next.pos_ok = 1'b0;
                    if (is_stop && crossed) begin
                        s_next.mode = ST_TRACK;
                    end
                end
                default: begin
                    s_next.mode = ST_TRACK;
                end
            endcase
        end
        if (tick) begin
            s_next.res.pos_valid = s_next.pos_ok;
            s_next.res.position = s_next.cur_pos;
            s_next.res.mark_valid = s_next.mark_pend;
            s_next.res.mark_chars = s_next.mark_chars;
            s_next.mark_pend = 1'b0;
            s_next.res_pend = 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            s_reg <= '0;
            s_reg.mode <= ST_TRACK;
        end else begin
            s_reg <= s_next;
        end
    end

    result_buffer u_buf (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_in_valid(s_reg.res_pend),
        .i_in_data(s_reg.res),
        .o_in_ready(buf_ready),
        .o_out_valid(O_RES_VALID),
        .o_out_data(O_RES),
        .i_out_ready(I_RES_READY)
    );

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);

    sequence s_switch_seen;
        fire && s_reg.mode == ST_TRACK && is_sw && crossed && pos_in && !near;
    endsequence

    sequence s_stop_seen;
        fire && s_reg.mode == ST_TRACK && is_stop && crossed && !is_sw;
    endsequence

    property p_coarse_grid;
        !I_GRID_FINE && $stable(I_GRID_FINE) && $changed(s_reg.tape_ref)
            |-> s_reg.tape_ref[1:0] == 2'h0;
    endproperty
    a_coarse_grid: assert property (p_coarse_grid) else $error("coarse ref off grid");

    property p_fine_grid;
        I_GRID_FINE && $stable(I_GRID_FINE) && $changed(s_reg.tape_ref)
            |-> (s_reg.tape_ref % 24'h000003) == 24'h000000;
    endproperty
    a_fine_grid: assert property (p_fine_grid) else $error("fine ref off grid");

    property p_switch;
        s_switch_seen |=> s_reg.tape_ref == $past(I_SCAN.pos_val) && s_reg.pos_ok
            && s_reg.mode == ST_TRACK;
    endproperty
    a_switch: assert property (p_switch) else $error("tape switch not taken");

    property p_hold_bound;
        s_reg.mode == ST_HOLD && s_reg.pos_ok |-> s_reg.cur_pos - s_reg.sw_mid <= 32'sd20
            && s_reg.cur_pos - s_reg.sw_mid >= -32'sd20;
    endproperty
    a_hold_bound: assert property (p_hold_bound) else $error("hold beyond half label");

    property p_stop;
        s_stop_seen |=> s_reg.mode == ST_STOP ##1 !s_reg.pos_ok;
    endproperty
    a_stop: assert property (p_stop) else $error("position after stop label");

    property p_marker;
        s_reg.mark_pend |-> is_marker(`MARKER_LEN, s_reg.mark_chars);
    endproperty
    a_marker: assert property (p_marker) else $error("bad marker accepted");

    property p_marker_take;
        fire && I_SCAN.ctrl_ok && is_marker(I_SCAN.ctrl_len, I_SCAN.ctrl_chars) && !tick
            |=> s_reg.mark_pend && s_reg.mark_chars == $past(I_SCAN.ctrl_chars);
    endproperty
    a_marker_take: assert property (p_marker_take) else $error("marker not kept");

    property p_result_rate;
        $rose(s_reg.res_pend) |-> $past(tick) && s_reg.res.pos_valid == $past(s_next.pos_ok);
    endproperty
    a_result_rate: assert property (p_result_rate) else $error("result off scan tick");

    property p_push;
        s_reg.res_pend && buf_ready && !tick |=> !s_reg.res_pend;
    endproperty
    a_push: assert property (p_push) else $error("result not handed on");

    property p_suppress;
        s_reg.mode == ST_STOP |-> !s_reg.pos_ok;
    endproperty
    a_suppress: assert property (p_suppress) else $error("valid while suppressed");

endmodule : tape_label_position_interpreter

// [tb/result_host_model.sv]
// host side model: takes results when not stalled, keeps the last one and the spacing
`timescale 1ns/1ps
module result_host_model
    import tape_label_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_stall,
    input wire logic i_valid,
    input wire result_t i_res,
    output logic o_ready,
    output result_t o_last,
    output int o_count,
    output int o_gap
);
    int cyc = 0;
    int last_cyc = 0;

    initial o_count = 0;
    initial o_gap = 0;
    initial o_last = '0;
    // a stalling host simply holds ready low; the result must stand meanwhile
    assign o_ready = !i_stall;

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (i_rst_n && i_valid && o_ready) begin
            o_last <= i_res;
            o_count <= o_count + 1;
            o_gap <= cyc - last_cyc;
            last_cyc <= cyc;
        end
    end
endmodule : result_host_model

// [tb/tb_tape_label_position_interpreter.sv]
// self-checking bench for the tape label position interpreter
`timescale 1ns/1ps
`include "tape_label_map.svh"
module tb_tape_label_position_interpreter;
    import tape_label_pkg::*;
    localparam int SCAN_CYC = 50;
    localparam int WATCH_NS = 200 * SCAN_CYC * 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic grid_fine = 1'b0;
    logic scan_valid = 1'b0;
    scan_t scan = '0;
    logic scan_ready;
    logic res_valid;
    result_t res;
    logic res_ready;
    logic stall = 1'b0;
    result_t host_last;
    result_t got;
    int host_count;
    int host_gap;
    int fail_count = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    tape_label_position_interpreter #(.SCAN_CYC(SCAN_CYC)) u_tape_label_position_interpreter (
        .I_CLK_SYS(clk),
        .I_RST_N(rst_n),
        .I_GRID_FINE(grid_fine),
        .I_SCAN_VALID(scan_valid),
        .I_SCAN(scan),
        .O_SCAN_READY(scan_ready),
        .O_RES_VALID(res_valid),
        .O_RES(res),
        .I_RES_READY(res_ready)
    );

    result_host_model u_result_host_model (
        .i_clk(clk),
        .i_rst_n(rst_n),
        .i_stall(stall),
        .i_valid(res_valid),
        .i_res(res),
        .o_ready(res_ready),
        .o_last(host_last),
        .o_count(host_count),
        .o_gap(host_gap)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic scan_t mk(input logic [23:0] ch, input int coff, input logic [23:0] v,
                                 input int poff);
        scan_t r;
        r.ctrl_ok = (ch != 24'h0);
        r.ctrl_len = `MARKER_LEN;
        r.ctrl_chars = ch;
        r.ctrl_off = 16'(coff);
        r.pos_ok = (v != 24'h0);
        r.pos_val = v;
        r.pos_off = 16'(poff);
        return r;
    endfunction : mk

    task automatic chk_pos(input logic ok, input int v, input int off);
        chk("pos_valid", 32'(ok), 32'(got.pos_valid));
        if (ok) chk("position", 32'(v * `MM_PER_COUNT - off), got.position);
    endtask : chk_pos

    task automatic do_reset(input logic fine);
        @(posedge clk);
        grid_fine <= fine;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic wait_res(input int n);
        for (int k = 0; k < 3 * SCAN_CYC && host_count < n; k++) @(negedge clk);
        chk("result arrives", 32'h1, 32'(host_count >= n));
        got = host_last;
    endtask : wait_res

    // sync to a fresh result so the record lands well before the next scan tick
    task automatic step(input scan_t rec);
        int n;
        wait_res(host_count + 1);
        @(posedge clk);
        scan_valid <= 1'b1;
        scan <= rec;
        @(negedge clk);
        for (int k = 0; k < 3 * SCAN_CYC && !scan_ready; k++) @(negedge clk);
        @(posedge clk);
        scan_valid <= 1'b0;
        scan <= ~rec;
        @(negedge clk);
        n = host_count;
        wait_res(n + 1);
    endtask : step

    task automatic t_coarse();
        do_reset(1'b0);
        step(mk(24'h0, 0, 24'h190, 5));
        chk_pos(1'b1, 24'h190, 5);
        step(mk(24'h0, 0, 24'h194, 0));
        chk_pos(1'b1, 24'h194, 0);
        step(mk(24'h0, 0, 24'h192, 0));
        chk_pos(1'b1, 24'h194, 0);
        $display("test coarse done");
    endtask : t_coarse

    task automatic t_fine();
        do_reset(1'b1);
        step(mk(24'h0, 0, 24'h12F, 0));
        chk_pos(1'b1, 24'h12F, 0);
        step(mk(24'h0, 0, 24'h132, 0));
        chk_pos(1'b1, 24'h132, 0);
        step(mk(24'h0, 0, 24'h134, 0));
        chk_pos(1'b1, 24'h132, 0);
        $display("test fine done");
    endtask : t_fine

    task automatic t_marker();
        logic [23:0] tab [6] = '{24'h413035, 24'h7A3939, 24'h403030, 24'h41303A,
                                 24'h5B3030, 24'h612F35};
        do_reset(1'b0);
        step(mk(24'h0, 0, 24'h190, 0));
        for (int i = 0; i < 6; i++) begin
            step(mk(tab[i], 0, 24'h0, 0));
            chk("mark_valid", 32'(i < 2), 32'(got.mark_valid));
            if (i < 2) chk("mark_chars", 32'(tab[i]), 32'(got.mark_chars));
            chk_pos(1'b1, 24'h190, 0);
        end
        step(mk(24'h0, 0, 24'h0, 0));
        chk("mark once", 32'h0, 32'(got.mark_valid));
        $display("test marker done");
    endtask : t_marker

    task automatic t_switch_far();
        do_reset(1'b0);
        step(mk(24'h0, 0, 24'h190, 0));
        step(mk(`SWITCH_CODE, 10, 24'h0, 0));
        step(mk(`SWITCH_CODE, -5, 24'h258, -5));
        chk_pos(1'b1, 24'h258, -5);
        step(mk(`SWITCH_CODE, 5, 24'h190, 5));
        chk_pos(1'b1, 24'h190, 5);
        $display("test switch far done");
    endtask : t_switch_far

    task automatic t_switch_hold();
        do_reset(1'b0);
        step(mk(24'h0, 0, 24'h190, 0));
        step(mk(`SWITCH_CODE, 10, 24'h0, 0));
        step(mk(`SWITCH_CODE, -5, 24'h0, 0));
        chk_pos(1'b1, 24'h190, -15);
        step(mk(`SWITCH_CODE, -25, 24'h0, 0));
        chk_pos(1'b0, 0, 0);
        step(mk(`SWITCH_CODE, -30, 24'h258, 0));
        chk_pos(1'b1, 24'h258, 0);
        $display("test switch hold done");
    endtask : t_switch_hold

    task automatic t_stop();
        do_reset(1'b0);
        step(mk(24'h0, 0, 24'h190, 0));
        step(mk(`STOP_CODE, 10, 24'h0, 0));
        chk_pos(1'b1, 24'h190, 0);
        step(mk(`STOP_CODE, -10, 24'h0, 0));
        chk_pos(1'b0, 0, 0);
        step(mk(24'h0, 0, 24'h194, 0));
        chk_pos(1'b0, 0, 0);
        $display("test stop done");
    endtask : t_stop

    task automatic t_stall();
        int n;
        do_reset(1'b0);
        step(mk(24'h0, 0, 24'h190, 0));
        chk("result spacing", 32'(SCAN_CYC), 32'(host_gap));
        @(posedge clk);
        stall <= 1'b1;
        repeat (4 * SCAN_CYC) @(negedge clk);
        chk("res_valid held", 32'h1, 32'(res_valid));
        chk("scan stalled", 32'h0, 32'(scan_ready));
        n = host_count;
        @(posedge clk);
        stall <= 1'b0;
        repeat (4) @(negedge clk);
        chk("drained", 32'h1, 32'(host_count - n >= 2));
        got = host_last;
        chk_pos(1'b1, 24'h190, 0);
        $display("test stall done");
    endtask : t_stall

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    initial begin
        t_coarse();
        t_fine();
        t_marker();
        t_switch_far();
        t_switch_hold();
        t_stop();
        t_stall();
        give_verdict();
    end

    initial begin
        #(WATCH_NS);
        fail_count++;
        give_verdict();
    end
endmodule : tb_tape_label_position_interpreter
